/* File: hw/bst_defines.svh */
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

// instruction register
`define BST_IR_LEN          10
`define BST_IR_CAPTURE      10'h001
`define BST_OP_EXTEST       10'h000
`define BST_OP_SAMPLE       10'h055
`define BST_OP_IDCODE       10'h006
`define BST_OP_USERCODE     10'h007
`define BST_OP_CFG_LOAD     10'h002
`define BST_OP_CFG_START    10'h003
`define BST_OP_BYPASS       10'h3FF

// data registers
`define BST_DR_LEN          32
`define BST_USER_BITS       7
// fixed upper part of the user signature, value is arbitrary
`define BST_USER_FIXED      25'h0A5_5A5A
// identification code, value is arbitrary (lsb must be one)
`define BST_IDCODE_DEFAULT  32'h0C0F_FEE1
`define BST_BSR_LEN         798

// configuration byte assembly
`define BST_CFG_BITS        8
`define BST_CFG_CNT_LAST    3'h7

// tap reset by tms held high over this many tck rises
`define BST_TMS_RESET_RISES 3'h5

`endif

/* File: hw/bst_pkg.sv */
package bst_pkg;

`include "bst_defines.svh"

    // tap states, gray coded along the scan path
    typedef enum logic [3:0] {
        BST_TAP_RESET    = 4'h0,
        BST_TAP_IDLE     = 4'h1,
        BST_TAP_SEL_DR   = 4'h3,
        BST_TAP_CAP_DR   = 4'h2,
        BST_TAP_SH_DR    = 4'h6,
        BST_TAP_EX1_DR   = 4'h7,
        BST_TAP_PAUSE_DR = 4'h5,
        BST_TAP_EX2_DR   = 4'h4,
        BST_TAP_UPD_DR   = 4'hC,
        BST_TAP_SEL_IR   = 4'hD,
        BST_TAP_CAP_IR   = 4'hF,
        BST_TAP_SH_IR    = 4'hE,
        BST_TAP_EX1_IR   = 4'hA,
        BST_TAP_PAUSE_IR = 4'hB,
        BST_TAP_EX2_IR   = 4'h9,
        BST_TAP_UPD_IR   = 4'h8
    } bst_tap_t;

    // data register chosen by the current instruction
    typedef enum logic [2:0] {
        BST_SEL_BYPASS = 3'h0,
        BST_SEL_SAMPLE = 3'h1,
        BST_SEL_EXTEST = 3'h3,
        BST_SEL_ID     = 3'h2,
        BST_SEL_USER   = 3'h6,
        BST_SEL_CFG    = 3'h7
    } bst_sel_t;

    // strobes from the tap into the boundary chain
    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic extest;
        logic sdi;
    } bst_bsr_ctl_t;

    // complete state of the tap controller
    typedef struct packed {
        logic                       tck_d;
        bst_tap_t                   tap;
        logic [`BST_IR_LEN-1:0]     ir_shift;
        logic [`BST_IR_LEN-1:0]     ir;
        logic                       bypass;
        logic [`BST_DR_LEN-1:0]     dr;
        logic [`BST_CFG_BITS-1:0]   cfg_sr;
        logic [2:0]                 cfg_cnt;
        logic [`BST_CFG_BITS-1:0]   cfg_data;
        logic                       cfg_valid;
        logic                       cfg_start;
        logic                       tdo;
        logic                       tdo_oe;
        bst_bsr_ctl_t               bsr_ctl;
    } bst_state_t;

endpackage

/* File: hw/bst_sync.sv */
`timescale 1ns/100ps
module bst_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_reset_n,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // two flops; the first one feeds nothing but the second
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

/* File: hw/bst_bsr.sv */
`timescale 1ns/100ps
`include "bst_defines.svh"
module bst_bsr
    import bst_pkg::*;
#(
    parameter int LEN = `BST_BSR_LEN
) (
    // clock and reset
    input  wire logic           i_mclk,
    input  wire logic           i_reset_n,
    // control from the tap
    input  wire bst_bsr_ctl_t   i_ctl,
    // pins and core
    input  wire logic [LEN-1:0] i_pin_in,
    input  wire logic [LEN-1:0] i_core_out,
    output logic      [LEN-1:0] o_pin_out,
    // serial out
    output logic                o_sdo
);

    typedef struct packed {
        logic [LEN-1:0] chain;
        logic [LEN-1:0] upd;
        logic [LEN-1:0] pin_out;
    } bst_bsr_state_t;

    bst_bsr_state_t st;
    bst_bsr_state_t next_st;

    // capture never touches the update stage, so sampling is invisible to pins
    always_comb begin
        next_st = st;
        if (i_ctl.capture) begin
            next_st.chain = i_pin_in;
        end else if (i_ctl.shift) begin
            next_st.chain = {i_ctl.sdi, st.chain[LEN-1:1]};
        end
        if (i_ctl.update) begin
            next_st.upd = st.chain;
        end
        next_st.pin_out = i_ctl.extest ? st.upd : i_core_out;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_pin_out = st.pin_out;
    assign o_sdo     = st.chain[0];

    sample_capture_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ctl.capture |=> st.chain == $past(i_pin_in))
        else $error("boundary chain missed pin capture");

    extest_drive_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ctl.extest |=> o_pin_out == $past(st.upd))
        else $error("pins not driven from update stage");

    functional_pins_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !i_ctl.extest |=> o_pin_out == $past(i_core_out))
        else $error("pins not under functional control");

endmodule

/* File: hw/bst_tap.sv */
`timescale 1ns/100ps
`include "bst_defines.svh"
module bst_tap
    import bst_pkg::*;
#(
    parameter int          BSR_LEN = `BST_BSR_LEN,
    parameter logic [31:0] ID_CODE = `BST_IDCODE_DEFAULT
) (
    // clock and reset
    input  wire logic                     i_mclk,
    input  wire logic                     i_reset_n,
    // test port pins
    input  wire logic                     i_tck,
    input  wire logic                     i_tms,
    input  wire logic                     i_tdi,
    output logic                          o_tdo,
    output logic                          o_tdo_oe,
    // device status and user design
    input  wire logic                     i_config_busy,
    input  wire logic [`BST_USER_BITS-1:0] i_user_sig,
    // pins and core
    input  wire logic [BSR_LEN-1:0]       i_pin_in,
    input  wire logic [BSR_LEN-1:0]       i_core_out,
    output logic      [BSR_LEN-1:0]       o_pin_out,
    output logic                          o_pin_test,
    // configuration data
    output logic [`BST_CFG_BITS-1:0]      o_cfg_data,
    output logic                          o_cfg_valid,
    output logic                          o_cfg_start
);

    bst_state_t st;
    bst_state_t next_st;
    logic       tck_s;
    logic       tms_s;
    logic       tdi_s;
    logic       bsr_sdo;
    logic       tck_rise;
    logic       tck_fall;
    bst_sel_t   sel;

    // standard tap state sequencing on tms
    function automatic bst_tap_t tap_step(input bst_tap_t t, input logic tms);
        bst_tap_t n;
        n = t;
        case (t)
            BST_TAP_RESET:    n = tms ? BST_TAP_RESET  : BST_TAP_IDLE;
            BST_TAP_IDLE:     n = tms ? BST_TAP_SEL_DR : BST_TAP_IDLE;
            BST_TAP_SEL_DR:   n = tms ? BST_TAP_SEL_IR : BST_TAP_CAP_DR;
            BST_TAP_CAP_DR:   n = tms ? BST_TAP_EX1_DR : BST_TAP_SH_DR;
            BST_TAP_SH_DR:    n = tms ? BST_TAP_EX1_DR : BST_TAP_SH_DR;
            BST_TAP_EX1_DR:   n = tms ? BST_TAP_UPD_DR : BST_TAP_PAUSE_DR;
            BST_TAP_PAUSE_DR: n = tms ? BST_TAP_EX2_DR : BST_TAP_PAUSE_DR;
            BST_TAP_EX2_DR:   n = tms ? BST_TAP_UPD_DR : BST_TAP_SH_DR;
            BST_TAP_UPD_DR:   n = tms ? BST_TAP_SEL_DR : BST_TAP_IDLE;
            BST_TAP_SEL_IR:   n = tms ? BST_TAP_RESET  : BST_TAP_CAP_IR;
            BST_TAP_CAP_IR:   n = tms ? BST_TAP_EX1_IR : BST_TAP_SH_IR;
            BST_TAP_SH_IR:    n = tms ? BST_TAP_EX1_IR : BST_TAP_SH_IR;
            BST_TAP_EX1_IR:   n = tms ? BST_TAP_UPD_IR : BST_TAP_PAUSE_IR;
            BST_TAP_PAUSE_IR: n = tms ? BST_TAP_EX2_IR : BST_TAP_PAUSE_IR;
            BST_TAP_EX2_IR:   n = tms ? BST_TAP_UPD_IR : BST_TAP_SH_IR;
            BST_TAP_UPD_IR:   n = tms ? BST_TAP_SEL_DR : BST_TAP_IDLE;
            default:          n = BST_TAP_RESET;
        endcase
        return n;
    endfunction

    // opcode decode; boundary tests fall back to bypass during configuration
    function automatic bst_sel_t decode(input logic [`BST_IR_LEN-1:0] ir, input logic busy);
        bst_sel_t s;
        s = BST_SEL_BYPASS;
        case (ir)
            `BST_OP_SAMPLE:   s = busy ? BST_SEL_BYPASS : BST_SEL_SAMPLE;
            `BST_OP_EXTEST:   s = busy ? BST_SEL_BYPASS : BST_SEL_EXTEST;
            `BST_OP_IDCODE:   s = BST_SEL_ID;
            `BST_OP_USERCODE: s = BST_SEL_USER;
            `BST_OP_CFG_LOAD: s = BST_SEL_CFG;
            default:          s = BST_SEL_BYPASS;
        endcase
        return s;
    endfunction

    // pins are asynchronous to i_mclk; tck is only ever sampled
    bst_sync #(
        .W (3)
    ) u_sync (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_tck, i_tms, i_tdi}),
        .o_sync    ({tck_s, tms_s, tdi_s})
    );

    // edge detection on the sampled tck
    assign tck_rise = tck_s & ~st.tck_d;
    assign tck_fall = ~tck_s & st.tck_d;
    assign sel      = decode(st.ir, i_config_busy);

    // one pass over the whole controller state
    always_comb begin
        next_st                 = st;
        next_st.tck_d           = tck_s;
        next_st.cfg_valid       = 1'b0;
        next_st.cfg_start       = 1'b0;
        next_st.bsr_ctl.capture = 1'b0;
        next_st.bsr_ctl.shift   = 1'b0;
        next_st.bsr_ctl.update  = 1'b0;
        next_st.bsr_ctl.sdi     = tdi_s;
        // extest only holds the pins outside test-logic-reset
        next_st.bsr_ctl.extest  = (sel == BST_SEL_EXTEST) && (st.tap != BST_TAP_RESET);
        if (tck_rise) begin
            next_st.tap = tap_step(st.tap, tms_s);
            case (st.tap)
                BST_TAP_RESET: begin
                    next_st.ir = `BST_OP_IDCODE;
                    next_st.bsr_ctl.extest = 1'b0;
                end
                BST_TAP_CAP_IR: begin
                    next_st.ir_shift = `BST_IR_CAPTURE;
                end
                BST_TAP_SH_IR: begin
                    next_st.ir_shift = {tdi_s, st.ir_shift[`BST_IR_LEN-1:1]};
                end
                BST_TAP_UPD_IR: begin
                    next_st.ir = st.ir_shift;
                    next_st.cfg_start = (st.ir_shift == `BST_OP_CFG_START);
                end
                BST_TAP_CAP_DR: begin
                    next_st.bypass  = 1'b0;
                    next_st.cfg_cnt = 3'h0;
                    case (sel)
                        BST_SEL_ID: begin
                            next_st.dr = ID_CODE;
                        end
                        BST_SEL_USER: begin
                            next_st.dr = {`BST_USER_FIXED, i_user_sig};
                        end
                        BST_SEL_SAMPLE, BST_SEL_EXTEST: begin
                            next_st.bsr_ctl.capture = 1'b1;
                        end
                        default: begin
                            next_st.dr = st.dr;
                        end
                    endcase
                end
                BST_TAP_SH_DR: begin
                    next_st.bypass = tdi_s;
                    case (sel)
                        BST_SEL_ID, BST_SEL_USER: begin
                            next_st.dr = {tdi_s, st.dr[`BST_DR_LEN-1:1]};
                        end
                        BST_SEL_SAMPLE, BST_SEL_EXTEST: begin
                            next_st.bsr_ctl.shift = 1'b1;
                        end
                        BST_SEL_CFG: begin
                            // bytes go out lsb first, as they were shifted in
                            next_st.cfg_sr  = {tdi_s, st.cfg_sr[`BST_CFG_BITS-1:1]};
                            next_st.cfg_cnt = 3'(st.cfg_cnt + 3'h1);
                            if (st.cfg_cnt == `BST_CFG_CNT_LAST) begin
                                next_st.cfg_data  = {tdi_s, st.cfg_sr[`BST_CFG_BITS-1:1]};
                                next_st.cfg_valid = 1'b1;
                            end
                        end
                        default: begin
                            next_st.dr = st.dr;
                        end
                    endcase
                end
                BST_TAP_UPD_DR: begin
                    // preload works under sample as well as extest
                    next_st.bsr_ctl.update = (sel == BST_SEL_SAMPLE) ||
                                             (sel == BST_SEL_EXTEST);
                end
                default: begin
                    next_st.ir = st.ir;
                end
            endcase
        end
        // tdo moves on the falling edge so the far end samples it stable
        if (tck_fall) begin
            next_st.tdo_oe = (st.tap == BST_TAP_SH_DR) || (st.tap == BST_TAP_SH_IR);
            if (st.tap == BST_TAP_SH_IR) begin
                next_st.tdo = st.ir_shift[0];
            end else begin
                case (sel)
                    BST_SEL_SAMPLE, BST_SEL_EXTEST: next_st.tdo = bsr_sdo;
                    BST_SEL_ID, BST_SEL_USER:       next_st.tdo = st.dr[0];
                    BST_SEL_CFG:                    next_st.tdo = st.cfg_sr[0];
                    default:                        next_st.tdo = st.bypass;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st     <= '0;
            st.ir  <= `BST_OP_IDCODE;
            st.tap <= BST_TAP_RESET;
        end else begin
            st <= next_st;
        end
    end

    // boundary chain with its update stage and pin multiplexer
    bst_bsr #(
        .LEN (BSR_LEN)
    ) u_bsr (
        .i_mclk     (i_mclk),
        .i_reset_n  (i_reset_n),
        .i_ctl      (st.bsr_ctl),
        .i_pin_in   (i_pin_in),
        .i_core_out (i_core_out),
        .o_pin_out  (o_pin_out),
        .o_sdo      (bsr_sdo)
    );

    // outputs straight from the state flops
    assign o_tdo       = st.tdo;
    assign o_tdo_oe    = st.tdo_oe;
    assign o_pin_test  = st.bsr_ctl.extest;
    assign o_cfg_data  = st.cfg_data;
    assign o_cfg_valid = st.cfg_valid;
    assign o_cfg_start = st.cfg_start;

    // helper: run of tck rises with tms high, saturating
    logic [2:0] tms_run;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tms_run <= 3'h0;
        end else if (tck_rise) begin
            tms_run <= !tms_s ? 3'h0 :
                       (tms_run == `BST_TMS_RESET_RISES) ? tms_run : 3'(tms_run + 3'h1);
        end
    end

    tap_reset_run_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (tms_run == `BST_TMS_RESET_RISES) |-> (st.tap == BST_TAP_RESET))
        else $error("five tms-high rises did not reach reset");

    reset_loads_id_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (tck_rise && st.tap == BST_TAP_RESET) |=> (st.ir == `BST_OP_IDCODE) && !o_pin_test)
        else $error("reset state did not restore identification");

    busy_blocks_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_config_busy |=> !o_pin_test && !st.bsr_ctl.capture)
        else $error("boundary test active during configuration");

    bypass_stage_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (tck_rise && st.tap == BST_TAP_SH_DR) |=> st.bypass == $past(tdi_s))
        else $error("bypass stage did not take tdi");

    user_capture_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (tck_rise && st.tap == BST_TAP_CAP_DR && sel == BST_SEL_USER)
        |=> st.dr == {`BST_USER_FIXED, $past(i_user_sig)})
        else $error("user signature captured wrong");

    id_capture_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (tck_rise && st.tap == BST_TAP_CAP_DR && sel == BST_SEL_ID) |=> st.dr == ID_CODE)
        else $error("identification code captured wrong");

    ir_update_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (tck_rise && st.tap == BST_TAP_UPD_IR) |=> st.ir == $past(st.ir_shift))
        else $error("instruction not loaded from shift stage");

    unknown_bypass_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (st.ir != `BST_OP_SAMPLE && st.ir != `BST_OP_EXTEST && st.ir != `BST_OP_IDCODE &&
         st.ir != `BST_OP_USERCODE && st.ir != `BST_OP_CFG_LOAD) |-> sel == BST_SEL_BYPASS)
        else $error("unassigned opcode not in bypass");

    cfg_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        o_cfg_valid |-> $past(sel) == BST_SEL_CFG ##1 !o_cfg_valid)
        else $error("configuration byte strobe malformed");

endmodule

/* File: verification/bst_jtag_model.sv */
`timescale 1ns/100ps
// test controller on the serial port; tck stands low outside frames
// every frame starts on a falling mclk edge so no pin moves with the sampling edge
module bst_jtag_model (
    // bench clock, only used to align frames
    input  wire logic i_mclk,
    // test port pins
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end

    // one tck cycle; tdo read just before the rise, settled since the fall
    task automatic tick(input logic m, input logic d, output logic q);
        o_tms = m;
        o_tdi = d;
        #60;
        q = i_tdo;
        o_tck = 1'b1;
        #65;
        o_tck = 1'b0;
    endtask

    // five tms-high rises reach test-logic-reset from any state
    task automatic tap_reset();
        logic q;
        @(negedge i_mclk);
        repeat (5) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask

    // idle to idle scan; exact bit counts are the caller's duty
    task automatic scan(input logic ir, input int n, input logic [437:0] din,
                        output logic [437:0] dout);
        logic q;
        @(negedge i_mclk);
        dout = '0;
        tick(1'b1, 1'b1, q);
        if (ir) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        tick(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        o_tdi = 1'b1; // tdi pulled up while idle
    endtask
endmodule

/* File: verification/bst_tap_tb_top.sv */
`timescale 1ns/100ps
`include "bst_defines.svh"
module bst_tap_tb_top;
    import bst_pkg::*;
    localparam int L = 438;

    // clock, reset and port wires
    logic                      mclk;
    logic                      reset_n;
    logic                      tck, tms, tdi, tdo, tdo_oe;
    logic                      busy, pin_test, cfg_valid, cfg_start;
    logic [`BST_USER_BITS-1:0] user_sig;
    logic [`BST_CFG_BITS-1:0]  cfg_data;
    logic [L-1:0]              pin_in, core_out, pin_out, din, dout, pat;
    logic [9:0]                op;
    logic [7:0]                cfg_q[$];
    int                        n_fail = 0;
    int                        total_checks = 0;
    int                        n_start = 0;
    int                        n_oe = 0;
    logic [31:0]               seed = 32'hdfe2_940a;

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    bst_tap #(.BSR_LEN(L)) dut_u (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_config_busy(busy), .i_user_sig(user_sig),
        .i_pin_in(pin_in), .i_core_out(core_out), .o_pin_out(pin_out),
        .o_pin_test(pin_test), .o_cfg_data(cfg_data), .o_cfg_valid(cfg_valid),
        .o_cfg_start(cfg_start));

    bst_jtag_model u_ctl (.i_mclk(mclk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));

    // gather bytes, start pulses and drive time away from the launching edge
    always @(negedge mclk) begin
        if (cfg_valid === 1'b1) cfg_q.push_back(cfg_data);
        if (cfg_start === 1'b1) n_start++;
        if (tdo_oe === 1'b1) n_oe++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [L-1:0] rvec();
        logic [L-1:0] v;
        v = '0;
        repeat (14) v = {v[L-33:0], rnd()};
        return v;
    endfunction

    task automatic chk_scan(input logic [L-1:0] got, input logic [L-1:0] exp,
                            input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t scan data %s", $time, what);
        end
    endtask

    task automatic chk_pin(input logic [L-1:0] got, input logic [L-1:0] exp,
                           input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t pin level %s", $time, what);
        end
    endtask

    // scan then let the pin strobes land before anyone looks
    task automatic run(input logic ir, input int n, input logic [L-1:0] d);
        u_ctl.scan(ir, n, d, dout);
        repeat (8) @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {reset_n, busy, user_sig, pin_in, core_out} = '0;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        core_out = rvec();
        pin_in = rvec();
        user_sig = 7'(rnd());
        u_ctl.tap_reset();
        run(1'b0, 32, rvec());
        chk_scan(dout, L'(`BST_IDCODE_DEFAULT), "idcode");
        chk_pin(L'(tdo_oe), '0, "tdo idle");
        // 32 shift periods of 125 ns, counted in 5 ns mclk cycles
        chk_pin(L'(n_oe), L'(32 * 25), "tdo driven in shift");
        run(1'b1, 10, L'(`BST_OP_USERCODE));
        chk_scan(dout, L'(`BST_IR_CAPTURE), "ir capture");
        run(1'b0, 32, rvec());
        chk_scan(dout, L'({`BST_USER_FIXED, user_sig}), "usercode");
        // bypass opcode, then unassigned ones from the upper half
        for (int k = 0; k < 4; k++) begin
            op = (k == 0) ? `BST_OP_BYPASS : {1'b1, 9'(rnd())};
            run(1'b1, 10, L'(op));
            pat = rvec();
            run(1'b0, 32, pat);
            chk_scan(dout, L'({pat[30:0], 1'b0}), "bypass");
        end
        run(1'b1, 10, L'(`BST_OP_SAMPLE));
        pat = rvec();
        run(1'b0, L, pat);
        chk_scan(dout, pin_in, "sample capture");
        chk_pin(pin_out, core_out, "sample leaves pins");
        chk_pin(L'(pin_test), '0, "sample mode");
        run(1'b1, 10, L'(`BST_OP_EXTEST));
        chk_pin(pin_out, pat, "preload driven");
        chk_pin(L'(pin_test), L'(1), "extest mode");
        @(negedge mclk);
        pin_in = rvec();
        din = rvec();
        run(1'b0, L, din);
        chk_scan(dout, pin_in, "extest capture");
        chk_pin(pin_out, din, "extest drive");
        u_ctl.tap_reset();
        repeat (8) @(posedge mclk);
        chk_pin(pin_out, core_out, "reset hands back");
        run(1'b0, 32, rvec());
        chk_scan(dout, L'(`BST_IDCODE_DEFAULT), "idcode after tap reset");
        // configuration running: extest falls back to bypass
        run(1'b1, 10, L'(`BST_OP_EXTEST));
        @(negedge mclk);
        busy = 1'b1;
        run(1'b0, 32, pat);
        chk_pin(pin_out, core_out, "busy pins");
        chk_scan(dout, L'({pat[30:0], 1'b0}), "busy bypass");
        @(negedge mclk);
        busy = 1'b0;
        // two whole bytes and a partial one that must be dropped
        run(1'b1, 10, L'(`BST_OP_CFG_LOAD));
        pat = rvec();
        run(1'b0, 20, pat);
        chk_pin(L'(cfg_q.size()), L'(2), "cfg byte count");
        chk_pin(L'({cfg_q[1], cfg_q[0]}), L'(pat[15:0]), "cfg bytes");
        run(1'b1, 10, L'(`BST_OP_CFG_START));
        chk_pin(L'(n_start), L'(1), "cfg start");
        complete_run();
    end

    // about two and a half times the expected run length
    initial begin
        #450000;
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
endmodule
